// ==== logic/rtc_top.sv ====
// Purpose: control logic of a passive read/write tag
// Assumes: gap detector and EEPROM answer synchronous to ref_clk
// Notes:   field clock is a one-cycle enable from a divider
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_top import rtc_pkg::*; #(
  parameter int DELAY_FC = `RTC_DELAY_FC,
  parameter int PROG_FC = `RTC_PROG_FC,
  parameter int FC_DIV = `RTC_FC_DIV
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic gap_det,
  input wire logic [32:0] eep_rdata,
  input wire logic eep_verify_ok,
  output logic [4:0] eep_addr,
  output logic [32:0] eep_wdata,
  output logic eep_prog,
  output logic damp,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // counters are 16 bits wide; a divider below 2 leaves no idle cycle between ticks
  if (DELAY_FC < 1 || DELAY_FC > 65535 || PROG_FC < 1 || PROG_FC > 65535 || FC_DIV < 2 ||
      FC_DIV > 65536) begin
    $error("rtc_top: unsupported parameter value");
  end

  rtc_state_t state;
  rtc_cfg_t cfg;
  logic fc_tick;
  logic [15:0] div_cnt;
  logic [15:0] tcnt;
  logic gap_q;
  logic [6:0] gap_len;
  logic [6:0] icnt;
  logic [39:0] sr;
  logic [5:0] nbits;
  logic direct;
  logic [4:0] cur_blk;
  logic [4:0] tgt_blk;
  logic start_ph;
  logic [5:0] bit_idx;
  logic [5:0] ph_cnt;
  logic prev_bit;
  logic psk_ph;
  logic sub_ph;
  logic soft_restart;

  // gap level seen on a field clock; onset and start gap qualifiers
  wire gap_on = fc_tick && gap_det && !gap_q;
  wire start_gap = fc_tick && gap_det && gap_len == 7'(`RTC_START_GAP_FC - 1);
  wire init_busy = state == ST_CFG || state == ST_DELAY;
  wire [5:0] period = cfg.bit_rate_select ? 6'(`RTC_RATE_SLOW) : 6'(`RTC_RATE_FAST);
  wire cur_bit = start_ph ? 1'b0 : eep_rdata[5'(31 - 32'(bit_idx[4:0]))];

  // first block of a cyclic stream
  function automatic logic [4:0] first_blk(input rtc_cfg_t c);
    first_blk = (c.last_block_limit == 5'h00) ? 5'h00 : 5'h01;
  endfunction

  // ----------------------------------------------------------------
  // field clock enable
  // ----------------------------------------------------------------
  // divider from the system clock stands in for the recovered carrier
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 16'h0000;
      fc_tick <= 1'b0;
    end else begin
      fc_tick <= div_cnt == 16'(FC_DIV - 1);
      div_cnt <= (div_cnt == 16'(FC_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // gap sampling and interval counting
  // ----------------------------------------------------------------
  // interval counts only field clocks outside gaps, the field is off inside
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= 1'b0;
      gap_len <= 7'h00;
      icnt <= 7'h00;
    end else if (fc_tick) begin
      gap_q <= gap_det;
      gap_len <= gap_det ? ((gap_len == 7'h7f) ? gap_len : gap_len + 7'h01) : 7'h00;
      if (gap_on || start_gap)
        icnt <= 7'h00;
      else if (!gap_det && icnt != 7'h7f)
        icnt <= icnt + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------
  // one counter serves configuration, delay and programming time
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_CFG;
      tcnt <= 16'h0000;
      cfg <= '0;
      sr <= 40'h00_0000_0000;
      nbits <= 6'h00;
      direct <= 1'b0;
      tgt_blk <= 5'h00;
      eep_wdata <= 33'h0_0000_0000;
      eep_prog <= 1'b0;
    end else begin
      eep_prog <= 1'b0;
      if (soft_restart) begin
        state <= ST_CFG;
        tcnt <= 16'h0000;
      end else if (init_busy && gap_on) begin
        state <= ST_CFG;
        tcnt <= 16'h0000;
      end else if (start_gap && !init_busy && state != ST_DOWN) begin
        state <= ST_DOWN;
        nbits <= 6'h00;
        direct <= 1'b0;
      end else if (fc_tick) begin
        case (state)
          ST_CFG: begin
            tcnt <= tcnt + 16'h0001;
            if (tcnt == 16'(`RTC_CFG_FC - 1)) begin
              cfg.last_block_limit <= eep_rdata[`RTC_CFG_LAST_BLOCK_LIMIT_LSB +: 5];
              cfg.startup_delay_setting <= eep_rdata[`RTC_CFG_SDELAY_BIT];
              cfg.bit_rate_select <= eep_rdata[`RTC_CFG_RATE_BIT];
              cfg.encoding_select <= eep_rdata[`RTC_CFG_ENC_BIT];
              cfg.transmit_suppress <= eep_rdata[`RTC_CFG_SUPP_BIT];
              tcnt <= 16'h0000;
              direct <= 1'b0;
              state <= eep_rdata[`RTC_CFG_SDELAY_BIT] ? ST_DELAY : ST_UP;
            end
          end
          ST_DELAY: begin
            tcnt <= tcnt + 16'h0001;
            if (tcnt == 16'(DELAY_FC - 1))
              state <= ST_UP;
          end
          ST_DOWN: begin
            if (gap_on) begin
              // classify the interval that this gap closes
              if (icnt >= 7'(`RTC_ZERO_MIN) && icnt <= 7'(`RTC_ZERO_MAX)) begin
                sr <= {sr[38:0], 1'b0};
                nbits <= (nbits == 6'h3f) ? nbits : nbits + 6'h01;
              end else if (icnt >= 7'(`RTC_ONE_MIN) && icnt <= 7'(`RTC_ONE_MAX)) begin
                sr <= {sr[38:0], 1'b1};
                nbits <= (nbits == 6'h3f) ? nbits : nbits + 6'h01;
              end else begin
                direct <= 1'b0;
                state <= ST_UP;
              end
            end else if (!gap_det && icnt == 7'(`RTC_ONE_MAX)) begin
              // silence ends the frame; its length picks the command
              state <= ST_UP;
              direct <= 1'b0;
              if (nbits == 6'(`RTC_LEN_RESET) && sr[1:0] == `RTC_OP_RESET) begin
                state <= ST_CFG;
                tcnt <= 16'h0000;
              end else if (nbits == 6'(`RTC_LEN_DIRECT) && sr[6:5] == `RTC_OP_STD) begin
                direct <= 1'b1;
                tgt_blk <= sr[4:0];
              end else if (nbits == 6'(`RTC_LEN_STD) && sr[39:38] == `RTC_OP_STD) begin
                eep_wdata <= sr[37:5];
                tgt_blk <= sr[4:0];
                state <= ST_LOCKCHK;
              end else if (nbits == 6'(`RTC_LEN_SHORT) && sr[37:36] == `RTC_OP_SHORT) begin
                eep_wdata <= sr[35:3];
                tgt_blk <= {2'b00, sr[2:0]};
                state <= ST_LOCKCHK;
              end
            end
          end
          ST_LOCKCHK: begin
            direct <= 1'b1;
            tcnt <= 16'h0000;
            if (eep_rdata[`RTC_LOCK_BIT])
              state <= ST_UP;
            else begin
              eep_prog <= 1'b1;
              state <= ST_PROG;
            end
          end
          ST_PROG: begin
            tcnt <= tcnt + 16'h0001;
            if (tcnt == 16'(PROG_FC - 1))
              state <= eep_verify_ok ? ST_UP : ST_DEFEAT;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // uplink bit timing and block walk
  // ----------------------------------------------------------------
  // restarted whenever the sequencer is outside uplink
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_ph <= 1'b1;
      bit_idx <= 6'h00;
      ph_cnt <= 6'h00;
      cur_blk <= 5'h00;
    end else if (state != ST_UP) begin
      start_ph <= 1'b1;
      bit_idx <= 6'h00;
      ph_cnt <= 6'h00;
      cur_blk <= (state == ST_CFG) ? 5'h00 : (direct ? tgt_blk : first_blk(cfg));
    end else if (start_ph && direct && cur_blk != tgt_blk) begin
      // direct mode rises on the entry edge itself; catch up before the data bits
      cur_blk <= tgt_blk;
    end else if (fc_tick) begin
      ph_cnt <= ph_cnt + 6'h01;
      if (ph_cnt == period - 6'h01) begin
        ph_cnt <= 6'h00;
        if (start_ph)
          start_ph <= 1'b0;
        else if (bit_idx == 6'd31) begin
          bit_idx <= 6'h00;
          if (direct)
            cur_blk <= tgt_blk;
          else if (cur_blk >= cfg.last_block_limit)
            cur_blk <= first_blk(cfg);
          else
            cur_blk <= cur_blk + 5'h01;
        end else
          bit_idx <= bit_idx + 6'h01;
      end
    end
  end

  // memory address follows the sequencer's need
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      eep_addr <= 5'h00;
    else if (state == ST_CFG)
      eep_addr <= 5'h00;
    else if (state == ST_LOCKCHK || state == ST_PROG)
      eep_addr <= tgt_blk;
    else
      eep_addr <= cur_blk;
  end

  // ----------------------------------------------------------------
  // modulator
  // ----------------------------------------------------------------
  // psk phase tracks data changes; subcarrier toggles every field clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_bit <= 1'b0;
      psk_ph <= 1'b0;
      sub_ph <= 1'b0;
    end else if (state != ST_UP) begin
      prev_bit <= 1'b0;
      psk_ph <= 1'b0;
      sub_ph <= 1'b0;
    end else if (fc_tick) begin
      sub_ph <= ~sub_ph;
      if (ph_cnt == 6'h00) begin
        prev_bit <= cur_bit;
        if (cur_bit != prev_bit)
          psk_ph <= ~psk_ph;
      end
    end
  end

  // load switch drive; held on in downlink, released while programming
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      damp <= 1'b0;
    else if (state == ST_DOWN)
      damp <= 1'b1;
    else if (state != ST_UP || cfg.transmit_suppress)
      damp <= 1'b0;
    else if (!cfg.encoding_select)
      damp <= sub_ph ^ psk_ph;
    else
      damp <= (ph_cnt < (period >> 1)) ? ~cur_bit : cur_bit;
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // restart pulse lets software rerun initialisation like a fresh field
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      soft_restart <= 1'b0;
    else
      soft_restart <= wr && addr == `RTC_REG_CTRL && wdata[`RTC_CTRL_RESTART];
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      rdata <= 32'h0000_0000;
    else if (!rd)
      rdata <= 32'h0000_0000;
    else begin
      case (addr)
        `RTC_REG_STATUS: rdata <= {17'h0_0000, direct, start_ph, cur_blk, bit_idx[4:0], state};
        `RTC_REG_CONFIG: rdata <= {23'h00_0000, cfg};
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  cfg_len_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == ST_CFG && fc_tick && tcnt == 16'(`RTC_CFG_FC - 1) && !gap_on && !soft_restart
    |=> state != ST_CFG)
    else $error("configuration period length wrong");
  delay_sel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(state) == ST_CFG && state == ST_DELAY |-> cfg.startup_delay_setting)
    else $error("startup delay taken while disabled");
  init_gap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    init_busy && gap_on |=> state == ST_CFG && tcnt == 16'h0000)
    else $error("gap did not restart initialisation");
  start_bit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == ST_UP && $past(state) != ST_UP |-> start_ph && !cur_bit)
    else $error("uplink entered without start bit");
  down_damp_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == ST_DOWN ##1 state == ST_DOWN |-> damp)
    else $error("damping released in downlink");
  start_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(init_busy) && !$past(soft_restart) |-> state != ST_DOWN)
    else $error("downlink entered during initialisation");
  timeout_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == ST_DOWN && fc_tick && !gap_det && icnt == 7'(`RTC_ONE_MAX) && !soft_restart
    |=> state != ST_DOWN)
    else $error("downlink not ended by silence");
  prog_quiet_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state == ST_PROG || state == ST_DEFEAT) ##1 (state == ST_PROG || state == ST_DEFEAT)
    |-> !damp)
    else $error("damping active while programming or defeated");
  lock_skip_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == ST_LOCKCHK && fc_tick && eep_rdata[`RTC_LOCK_BIT] && !soft_restart && !start_gap
    |=> state == ST_UP && !eep_prog)
    else $error("locked block was programmed");
  direct_blk_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == ST_UP && direct && !start_ph |-> cur_blk == tgt_blk)
    else $error("direct access sends another block");
  direct_c: cover property (@(posedge ref_clk) state == ST_UP && direct && bit_idx == 6'd31);
  write_ok_c: cover property (@(posedge ref_clk) state == ST_PROG ##1 state == ST_UP);
  defeat_c: cover property (@(posedge ref_clk) state == ST_DEFEAT ##1 state == ST_DOWN);
  reset_cmd_c: cover property (@(posedge ref_clk) state == ST_DOWN ##1 state == ST_CFG);
endmodule
`default_nettype wire

// ==== include/rtc_defines.svh ====
// Purpose: named constants of the tag controller
// Assumes: field clock recovered at 125 kHz, system clock at 25 MHz
// Notes:   definitions only
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define RTC_CLK_HZ 25000000
`define RTC_FIELD_HZ 125000
`define RTC_FC_DIV (`RTC_CLK_HZ / `RTC_FIELD_HZ)
`define RTC_CFG_FC 114
`define RTC_DELAY_FC 8192
`define RTC_PROG_TIME_US 18000
`define RTC_PROG_FC (`RTC_PROG_TIME_US * (`RTC_FIELD_HZ / 1000) / 1000)
`define RTC_START_GAP_FC 40
`define RTC_ZERO_MIN 16
`define RTC_ZERO_MAX 32
`define RTC_ONE_MIN 48
`define RTC_ONE_MAX 64
`define RTC_RATE_SLOW 32
`define RTC_RATE_FAST 16
// ----------------------------------------------------------------
// frame lengths and opcodes
// ----------------------------------------------------------------
`define RTC_LEN_RESET 2
`define RTC_LEN_DIRECT 7
`define RTC_LEN_SHORT 38
`define RTC_LEN_STD 40
`define RTC_OP_RESET 2'h0
`define RTC_OP_SHORT 2'h2
`define RTC_OP_STD 2'h3
// ----------------------------------------------------------------
// configuration block 0 field positions, lock bit of every block
// ----------------------------------------------------------------
`define RTC_CFG_LAST_BLOCK_LIMIT_LSB 0
`define RTC_CFG_SDELAY_BIT 5
`define RTC_CFG_RATE_BIT 6
`define RTC_CFG_ENC_BIT 7
`define RTC_CFG_SUPP_BIT 8
`define RTC_LOCK_BIT 32
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define RTC_REG_CTRL 4'h0
`define RTC_REG_STATUS 4'h4
`define RTC_REG_CONFIG 4'h8
`define RTC_CTRL_RESTART 0
`endif

// ==== include/rtc_pkg.sv ====
// Purpose: shared types of the tag controller
// Assumes: used together with rtc_defines.svh
// Notes:   states, configuration carrier
package rtc_pkg;
  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CFG = 3'b000,
    ST_DELAY = 3'b001,
    ST_UP = 3'b010,
    ST_DOWN = 3'b011,
    ST_LOCKCHK = 3'b100,
    ST_PROG = 3'b101,
    ST_DEFEAT = 3'b110
  } rtc_state_t;
  // ----------------------------------------------------------------
  // mode settings taken from block 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic transmit_suppress;
    logic encoding_select;
    logic bit_rate_select;
    logic startup_delay_setting;
    logic [4:0] last_block_limit;
  } rtc_cfg_t;
endpackage

// ==== verification/rtc_reader_model.sv ====
// Purpose: reader gap source and block memory beside the tag controller
// Assumes: one field clock lasts FC_DIV ref_clk cycles
// Notes:   bench calls hold and send_bits; verify_pass steers the verify answer
`timescale 1ns/1ps
`default_nettype none
module rtc_reader_model #(
  parameter int FC_DIV = 4
) (
  input wire logic ref_clk,
  input wire logic [4:0] eep_addr,
  input wire logic [32:0] eep_wdata,
  input wire logic eep_prog,
  output logic [32:0] eep_rdata,
  output logic eep_verify_ok,
  output logic gap_det
);
  logic [32:0] mem [32];
  logic verify_pass;
  // ----------------------------------------------------------------
  // block memory
  // ----------------------------------------------------------------
  // block 0: limit 2, startup delay on, manchester, fast rate; block 4 locked
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = {1'b0, 24'h5a3c00, 3'h0, i[4:0]};
    end
    mem[0] = 33'h0_000000a2;
    mem[4][32] = 1'b1;
    verify_pass = 1'b1;
    gap_det = 1'b0;
  end
  // combinational read, so the answer is ready before the next field tick
  assign eep_rdata = mem[eep_addr];
  assign eep_verify_ok = verify_pass;
  // a failed verify leaves the cell untouched, as a worn cell would
  always @(posedge ref_clk) begin
    if (eep_prog === 1'b1 && verify_pass) begin
      mem[eep_addr] <= eep_wdata;
    end
  end
  // ----------------------------------------------------------------
  // field gaps
  // ----------------------------------------------------------------
  // field on or off for n field clocks
  task automatic hold(input logic lvl, input int n);
    gap_det <= lvl;
    repeat (n * FC_DIV) @(posedge ref_clk);
  endtask
  // msb first, one gap after each bit; bad index sends an illegal spacing
  task automatic send_bits(input logic [39:0] b, input int n, input int bad);
    for (int i = n - 1; i >= 0; i--) begin
      hold(1'b0, (i == bad) ? 40 : (b[i] ? 56 : 24));
      hold(1'b1, 3);
      if (i == bad) begin
        gap_det <= 1'b0; // field back on after an aborted frame
        return;
      end
    end
    hold(1'b0, 66);
  endtask
endmodule
`default_nettype wire

// ==== verification/rtc_top_bench.sv ====
// Purpose: self-checking bench of the tag controller
// Assumes: short counts DELAY_FC 8, PROG_FC 10, FC_DIV 4
// Notes:   status is polled over the register port
`timescale 1ns/1ps
`default_nettype none
module rtc_top_bench import rtc_pkg::*; ;
  logic ref_clk, arst_n, wr, rd, gap_det, eep_verify_ok, eep_prog, damp, last_damp;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, st;
  logic [32:0] eep_rdata, eep_wdata;
  logic [4:0] eep_addr;
  int miscompares = 0;
  int n_checks = 0;
  int n_prog = 0;
  int n_damp = 0;
  int p0;
  rtc_top #(.DELAY_FC(8), .PROG_FC(10), .FC_DIV(4)) i_rtc_top (
    .ref_clk(ref_clk), .arst_n(arst_n), .gap_det(gap_det), .eep_rdata(eep_rdata),
    .eep_verify_ok(eep_verify_ok), .eep_addr(eep_addr), .eep_wdata(eep_wdata),
    .eep_prog(eep_prog), .damp(damp), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata)
  );
  rtc_reader_model #(.FC_DIV(4)) i_rtc_reader_model (
    .ref_clk(ref_clk), .eep_addr(eep_addr), .eep_wdata(eep_wdata), .eep_prog(eep_prog),
    .eep_rdata(eep_rdata), .eep_verify_ok(eep_verify_ok), .gap_det(gap_det)
  );
  // ----------------------------------------------------------------
  // clock, watchers, watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // program pulses and damping edges, counted for later comparison
  always @(posedge ref_clk) begin
    if (eep_prog === 1'b1) n_prog++;
    if (damp !== last_damp) n_damp++;
    last_damp <= damp;
  end
  // whole run is near 37k cycles; the margin covers slow uplink blocks
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 st = rdata;
  endtask
  // poll status until the masked fields match, bounded by lim reads
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd_reg(4'h4);
      if ((st & m) === v) break;
    end
    chk(st & m, v);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    last_damp = 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    // config 114 ticks, then 8 ticks of delay, then uplink
    repeat (438) @(posedge ref_clk);
    rd_reg(4'h4);
    chk(32'(st[2:0]), 32'(ST_CFG));
    repeat (30) @(posedge ref_clk);
    rd_reg(4'h4);
    chk(32'(st[2:0]), 32'(ST_DELAY));
    wait_st(32'h7, 32'(ST_UP), 40);
    rd_reg(4'h8);
    chk(st, 32'h0a2);
    rd_reg(4'hc);
    chk(st, 32'h0);
    // soft restart, then a gap at tick 100 must restart the count
    wr_reg(4'h0, 32'h1);
    repeat (400) @(posedge ref_clk);
    i_rtc_reader_model.hold(1'b1, 3);
    i_rtc_reader_model.hold(1'b0, 45);
    rd_reg(4'h4);
    chk(32'(st[2:0]), 32'(ST_CFG));
    wait_st(32'h7, 32'(ST_UP), 300);
    chk(32'(st[13]), 32'h1);
    chk(32'(st[12:8]), 32'h1);
    // manchester gives at least one damping edge per bit
    n_damp = 0;
    repeat (2048) @(posedge ref_clk);
    chk(32'(n_damp >= 32), 32'h1);
    wait_st(32'h1f00, 32'h200, 1200);
    wait_st(32'h1f00, 32'h100, 1200);
    // start gap, damping held, direct access to block 5
    i_rtc_reader_model.hold(1'b1, 44);
    rd_reg(4'h4);
    chk(32'(st[2:0]), 32'(ST_DOWN));
    chk(32'(damp), 32'h1);
    i_rtc_reader_model.send_bits(40'h65, 7, -1);
    wait_st(32'h5f07, 32'h4502, 100);
    // standard write to block 3, verify passes
    i_rtc_reader_model.hold(1'b1, 44);
    i_rtc_reader_model.send_bits({2'b11, 1'b0, 32'hc3a5_0f96, 5'd3}, 40, -1);
    rd_reg(4'h4);
    chk(32'(st[2:0]), 32'(ST_PROG));
    chk(32'(damp), 32'h0);
    chk(32'(n_prog), 32'h1);
    chk(eep_wdata[31:0], 32'hc3a5_0f96);
    chk(32'(eep_addr), 32'h3);
    wait_st(32'h1f07, 32'h0302, 100);
    // short write to block 6, verify fails
    i_rtc_reader_model.verify_pass = 1'b0;
    i_rtc_reader_model.hold(1'b1, 44);
    i_rtc_reader_model.send_bits({2'b00, 2'b10, 1'b0, 32'h1234_abcd, 3'd6}, 38, -1);
    wait_st(32'h7, 32'(ST_DEFEAT), 100);
    chk(32'(eep_addr), 32'h6);
    repeat (200) @(posedge ref_clk);
    chk(32'(damp), 32'h0);
    i_rtc_reader_model.verify_pass = 1'b1;
    // start gap leaves defeat; an illegal spacing returns to block 1
    i_rtc_reader_model.hold(1'b1, 44);
    rd_reg(4'h4);
    chk(32'(st[2:0]), 32'(ST_DOWN));
    i_rtc_reader_model.send_bits({2'b11, 38'h0}, 40, 34);
    wait_st(32'h1f07, 32'h0102, 100);
    // write to locked block 4 skips programming
    p0 = n_prog;
    i_rtc_reader_model.hold(1'b1, 44);
    i_rtc_reader_model.send_bits({2'b11, 1'b0, 32'h0f0f_f0f0, 5'd4}, 40, -1);
    wait_st(32'h1f07, 32'h0402, 100);
    chk(32'(n_prog), 32'(p0));
    // block 0 rewritten for psk, slow rate, limit 1, no delay
    i_rtc_reader_model.hold(1'b1, 44);
    i_rtc_reader_model.send_bits({2'b11, 1'b0, 32'h0000_0041, 5'd0}, 40, -1);
    wait_st(32'h1f07, 32'h0002, 100);
    // reset opcode reruns initialisation with the new settings
    i_rtc_reader_model.hold(1'b1, 44);
    i_rtc_reader_model.send_bits(40'h0, 2, -1);
    wait_st(32'h7, 32'(ST_CFG), 60);
    wait_st(32'h7, 32'(ST_UP), 300);
    // start bit still running after 25 field clocks at the slow rate
    repeat (100) @(posedge ref_clk);
    rd_reg(4'h4);
    chk(32'(st[13]), 32'h1);
    rd_reg(4'h8);
    chk(st, 32'h041);
    // psk subcarrier flips the load nearly every field clock
    n_damp = 0;
    repeat (256) @(posedge ref_clk);
    chk(32'(n_damp >= 32), 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
